/* bench/clock_synth_control_bytes_assertions.sv */
/*
 Port-level assertions for the clock synthesizer control bytes.
 Assumes it is bound to the design top and sees only its ports.
*/
`default_nettype none
module clock_synth_control_bytes_assertions
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] addr_byte,
   input wire logic addr_valid,
   input wire logic [7:0] cmd_code,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic power_down_pin,
   input wire logic cpu_clock_halt_pin,
   input wire logic bus_clock_halt_pin,
   input wire logic addr_ack,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic cmd_error,
   input wire logic mgmt_mode,
   input wire logic main_src_is_pll3,
   input wire logic [3:0] pll_three_cfg,
   input wire logic panel_clock_run,
   input wire logic diff_refs_run
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_addr_answer: assert property (1'b1 |=> addr_ack == $past(addr_valid && addr_byte[7:1] == 7'h69))
      else $error("address acknowledge wrong");
   a_read_pulse: assert property (1'b1 |=> rd_valid == $past(rd_strobe))
      else $error("read valid not one cycle after strobe");
   a_read_hold: assert property (!rd_valid |-> $stable(rd_data))
      else $error("read data moved without read");
   a_block_index_err: assert property ((wr_strobe || rd_strobe) && !cmd_code[7] && cmd_code[6:0] != 7'h00 |=> cmd_error)
      else $error("block access with index not flagged");
   a_unmapped_zero: assert property (rd_strobe && cmd_code[7] && cmd_code[6:0] > 7'h06 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_cfg_forced: assert property (main_src_is_pll3 |-> pll_three_cfg == 4'h1)
      else $error("pll three code not forced");
   a_mgmt_combo: assert property (power_down_pin && !cpu_clock_halt_pin && !bus_clock_halt_pin |-> ##2 mgmt_mode)
      else $error("pin combination did not set management mode");
   a_free_run: assert property (!bus_clock_halt_pin [*2] |-> ##1 (panel_clock_run && diff_refs_run))
      else $error("outputs stopped without halt pin");
endmodule
bind clock_synth_control_bytes clock_synth_control_bytes_assertions clock_synth_control_bytes_assertions_i
(
   .ref_clk, .rstn, .addr_byte, .addr_valid, .cmd_code, .wr_strobe, .rd_strobe, .power_down_pin,
   .cpu_clock_halt_pin, .bus_clock_halt_pin, .addr_ack, .rd_data, .rd_valid, .cmd_error, .mgmt_mode,
   .main_src_is_pll3, .pll_three_cfg, .panel_clock_run, .diff_refs_run
);
`default_nettype wire

/* bench/smbus_host_model.sv */
/*
 Host side of the decoded serial port: address, start, write and read strobes.
 Assumes ref_clk is the block clock; requests change 1 ns after a rising edge.
*/
`default_nettype none
module smbus_host_model
(
   input wire logic ref_clk,
   output logic [7:0] addr_byte,
   output logic addr_valid,
   output logic xfer_start,
   output logic [7:0] cmd_code,
   output logic wr_strobe,
   output logic [7:0] wr_data,
   output logic rd_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {addr_byte, addr_valid, xfer_start, cmd_code, wr_strobe, wr_data, rd_strobe} = '0;
   end
   // k: 100 address, 011 start, 010 write, 001 read; one idle cycle between requests
   task op(input logic [2:0] k, input logic [7:0] c, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      addr_byte = d;
      addr_valid = k[2];
      xfer_start = k[1] & k[0];
      cmd_code = c;
      wr_strobe = k[1] & !k[0];
      wr_data = d;
      rd_strobe = k[0] & !k[1];
      @(posedge ref_clk);
      #1;
      {addr_valid, xfer_start, wr_strobe, rd_strobe} = 4'h0;
      // Released data lines must not keep showing the old byte
      wr_data = ~d;
      addr_byte = ~d;
   endtask
endmodule
`default_nettype wire

/* bench/test_clock_synth_control_bytes.sv */
/*
 Self-checking bench for the clock synthesizer control bytes.
 Assumes straps settle before power_good; clock requests stay asserted outside the gating scenario.
*/
`default_nettype none
module test_clock_synth_control_bytes;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rstn, addr_valid, xfer_start, wr_strobe, rd_strobe, power_good, power_down_pin;
   logic cpu_freq_strap_hi, cpu_freq_strap_mid, cpu_freq_strap_lo, graphics_clock_strap;
   logic cpu_clock_halt_pin, bus_clock_halt_pin, addr_ack, rd_valid, cmd_error, mgmt_mode, main_src_is_pll3;
   logic storage_src_is_pll2, dot_selected, panel_clock_run, diff_refs_run;
   logic [7:0] addr_byte, cmd_code, wr_data, clkreq_n, rd_data, single_ended_oe, d;
   logic [11:0] diff_ref_oe;
   logic [1:0] cpu_oe, spread_center, spread_on;
   logic [3:0] pll_three_cfg;
   logic [31:0] rs = 32'hC0BA;
   logic [7:0] expq[$];
   int checks = 0, n_mismatch = 0;
   localparam logic [7:0] RV [8] = '{8'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WM [8] = '{8'h17, 8'h7E, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hF3, 8'h00};
   logic [7:0] mdl [8] = RV;
   clock_synth_control_bytes clock_synth_control_bytes_i (.*);
   smbus_host_model smbus_host_model_i (.ref_clk, .addr_byte, .addr_valid, .xfer_start, .cmd_code, .wr_strobe,
      .wr_data, .rd_strobe);
   function automatic logic [7:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[7:0];
   endfunction
   task automatic cmp(string n, logic [11:0] e, logic [11:0] s);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] c, int i, logic [7:0] v);
      smbus_host_model_i.op(3'b010, c, v);
      mdl[i] = (v & WM[i]) | (mdl[i] & ~WM[i]);
   endtask
   task automatic rd(logic [7:0] c, int i);
      expq.push_back(i == 0 ? {3'b101, mdl[0][4:0]} : i == 1 ? {1'b1, mdl[1][6:0]} : mdl[i]);
      smbus_host_model_i.op(3'b001, c, 8'h00);
   endtask
   task automatic outs();
      repeat (3) @(posedge ref_clk);
      #1;
      cmp("single_ended_oe", mdl[2], single_ended_oe);
      cmp("diff_ref_oe", {mdl[3][7:2], 1'b0, mdl[3][0], mdl[4][7:4]}, diff_ref_oe);
      cmp("cpu_oe spread_on", mdl[4][3:0], {cpu_oe, spread_on});
      cmp("selects", {mdl[0][4], mdl[0][2:1], mdl[1][6:5]}, {mgmt_mode, main_src_is_pll3, storage_src_is_pll2,
         spread_center});
      cmp("pll_three_cfg", mdl[0][2] ? 4'h1 : mdl[1][4:1], pll_three_cfg);
      cmp("dot_selected", 1'b1, dot_selected);
   endtask
   task final_report;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      ref_clk = 0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (rd_valid === 1'b1)
      begin
         if (expq.size() == 0)
            cmp("unexpected rd_valid", 12'h0, 12'h1);
         else
            cmp("rd_data", expq.pop_front(), rd_data);
      end
   initial
   begin
      #50000;
      n_mismatch++;
      final_report;
   end
   initial
   begin
      {rstn, power_good, power_down_pin, cpu_clock_halt_pin, bus_clock_halt_pin, clkreq_n} = '0;
      {cpu_freq_strap_hi, cpu_freq_strap_mid, cpu_freq_strap_lo, graphics_clock_strap} = 4'hA;
      repeat (3) @(posedge ref_clk);
      #1;
      rstn = 1;
      power_good = 1;
      smbus_host_model_i.op(3'b100, 8'h00, 8'hD2);
      cmp("addr_ack", 1'b1, addr_ack);
      smbus_host_model_i.op(3'b100, 8'h00, 8'hD4);
      cmp("addr_ack", 1'b0, addr_ack);
      for (int i = 0; i < 8; i++) rd(8'h80 | 8'(i), i);
      outs();
      for (int n = 0; n < 40; n++)
      begin
         d = rnd();
         wr(8'h80 | {5'h0, d[2:0]}, d[2:0], rnd());
         rd(8'h80 | {5'h0, d[2:0]}, d[2:0]);
      end
      outs();
      smbus_host_model_i.op(3'b011, 8'h00, 8'h00);
      for (int i = 0; i < 7; i++) wr(8'h00, i, rnd());
      smbus_host_model_i.op(3'b011, 8'h00, 8'h00);
      for (int i = 0; i < 7; i++) rd(8'h00, i);
      wr(8'h80, 0, 8'h00);
      // Halt pin held up so the power-down does not also raise management mode
      cpu_clock_halt_pin = 1;
      power_down_pin = 1;
      repeat (3) @(posedge ref_clk);
      #1;
      power_down_pin = 0;
      cpu_clock_halt_pin = 0;
      mdl = RV;
      for (int i = 0; i < 7; i++) rd(8'h80 | 8'(i), i);
      power_down_pin = 1;
      repeat (3) @(posedge ref_clk);
      #1;
      power_down_pin = 0;
      mdl[0][4] = 1'b1;
      rd(8'h80, 0);
      outs();
      // Requests A and E released with their enables on, and the bus halt pin raised
      wr(8'h85, 5, 8'h80);
      wr(8'h86, 6, 8'h83);
      clkreq_n = 8'h11;
      bus_clock_halt_pin = 1;
      repeat (3) @(posedge ref_clk);
      #1;
      cmp("diff_ref_oe gated", {mdl[3][7:2], 1'b0, mdl[3][0], mdl[4][7:4]} & 12'hFBE, diff_ref_oe);
      cmp("halt run", 2'b00, {panel_clock_run, diff_refs_run});
      clkreq_n = 8'h00;
      bus_clock_halt_pin = 0;
      smbus_host_model_i.op(3'b010, 8'h05, 8'h00);
      cmp("cmd_error", 1'b1, cmd_error);
      final_report;
   end
endmodule
`default_nettype wire

/* logic/clock_synth_control_bytes.v */
/*
 Control bytes 0 to 6 of a multi-output clock synthesizer, with their decoded control outputs.
 Assumes a serial protocol engine in front that passes on the address byte for this block to match, decoded bytes into
 write/read strobes with a command code, and that strap pins are synchronous to ref_clk.
*/
`include "clock_synth_control_defines.vh"
`default_nettype none
module clock_synth_control_bytes
(
   input wire ref_clk,
   input wire rstn,
   input wire [7:0] addr_byte,
   input wire addr_valid,
   input wire xfer_start,
   input wire [7:0] cmd_code,
   input wire wr_strobe,
   input wire [7:0] wr_data,
   input wire rd_strobe,
   input wire cpu_freq_strap_hi,
   input wire cpu_freq_strap_mid,
   input wire cpu_freq_strap_lo,
   input wire graphics_clock_strap,
   input wire power_good,
   input wire power_down_pin,
   input wire cpu_clock_halt_pin,
   input wire bus_clock_halt_pin,
   input wire [7:0] clkreq_n,
   output reg addr_ack,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg cmd_error,
   output reg [7:0] single_ended_oe,
   output reg [11:0] diff_ref_oe,
   output reg [1:0] cpu_oe,
   output reg mgmt_mode,
   output reg main_src_is_pll3,
   output reg storage_src_is_pll2,
   output reg dot_selected,
   output reg [1:0] spread_center,
   output reg [1:0] spread_on,
   output reg [3:0] pll_three_cfg,
   output reg panel_clock_run,
   output reg diff_refs_run
);
   localparam NBYTES = 7;

   reg [7:0] byte_reg [0:NBYTES-1];
   reg [7:0] byte_next [0:NBYTES-1];
   reg [6:0] idx_reg;
   reg [6:0] idx_next;
   reg straps_taken_reg;
   reg [2:0] freq_strap_reg;
   reg dot_strap_reg;
   reg pd_seen_reg;
   wire single_mode;
   wire [6:0] cmd_index;
   wire [6:0] acc_index;
   wire in_range;
   wire pd_edge;
   wire mgmt_combo;
   reg [7:0] rd_mux;
   reg [7:0] wmask;
   reg [7:0] rst_val;
   reg [11:0] diff_oe_next;

   wire req_a_idle;
   wire req_b_idle;
   wire req_c_idle;
   wire req_d_idle;
   wire req_e_idle;
   wire req_f_idle;
   wire req_g_idle;
   wire req_h_idle;
   wire stop_out0;
   wire stop_out1;
   wire stop_out2;
   wire stop_out4;
   integer i;

   assign single_mode = cmd_code[`CMD_SINGLE_BIT];
   assign cmd_index = cmd_code[6:0];
   assign acc_index = single_mode ? cmd_index : idx_reg;
   assign in_range = acc_index <= `IDX_LAST;
   assign pd_edge = power_down_pin & ~pd_seen_reg;
   // Power-down with both halt pins low enters management mode
   assign mgmt_combo = power_down_pin & ~cpu_clock_halt_pin & ~bus_clock_halt_pin;

   // An enabled request whose active-low pin is high asks for its output to stop
   assign req_a_idle = byte_reg[5][7] & clkreq_n[0];
   assign req_b_idle = byte_reg[5][5] & clkreq_n[1];
   assign req_c_idle = byte_reg[5][3] & clkreq_n[2];
   assign req_d_idle = byte_reg[5][1] & clkreq_n[3];
   assign req_e_idle = byte_reg[6][7] & clkreq_n[4];
   assign req_f_idle = byte_reg[6][6] & clkreq_n[5];
   assign req_g_idle = byte_reg[6][5] & clkreq_n[6];
   assign req_h_idle = byte_reg[6][4] & clkreq_n[7];
   // Routed requests: the route bit picks one of two outputs
   assign stop_out0 = (req_a_idle & ~byte_reg[5][6]) | (req_c_idle & ~byte_reg[5][2]);
   assign stop_out2 = (req_a_idle & byte_reg[5][6]) | (req_c_idle & byte_reg[5][2]);
   assign stop_out1 = (req_b_idle & ~byte_reg[5][4]) | (req_d_idle & ~byte_reg[5][0]);
   assign stop_out4 = (req_b_idle & byte_reg[5][4]) | (req_d_idle & byte_reg[5][0]);

   // Straps are caught once, on the first clock seen with power good high
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         straps_taken_reg <= 1'b0;
         freq_strap_reg <= 3'h0;
         dot_strap_reg <= 1'b0;
      end
      else if (power_good && !straps_taken_reg)
      begin
         straps_taken_reg <= 1'b1;
         freq_strap_reg <= {cpu_freq_strap_hi, cpu_freq_strap_mid, cpu_freq_strap_lo};
         dot_strap_reg <= graphics_clock_strap;
      end
   end

   always @*
   begin
      rd_mux = 8'h00;
      case (acc_index)
         `IDX_FREQ_STRAP_AND_SOURCE_SELECT: rd_mux = {freq_strap_reg, byte_reg[0][4:0]};
         `IDX_SPREAD_TYPE_AND_PLL3_CONFIG: rd_mux = {~dot_strap_reg, byte_reg[1][6:0]};
         `IDX_SINGLE_ENDED_OUTPUT_ENABLES: rd_mux = byte_reg[2];
         `IDX_UPPER_DIFF_OUTPUT_ENABLES: rd_mux = byte_reg[3];
         `IDX_LOWER_DIFF_AND_CPU_ENABLES: rd_mux = byte_reg[4];
         `IDX_CLOCK_REQUEST_ROUTING_A_TO_D: rd_mux = byte_reg[5];
         `IDX_CLOCK_REQUEST_E_TO_H_AND_STOP: rd_mux = byte_reg[6];
         default: rd_mux = 8'h00;
      endcase
   end

   always @*
   begin
      wmask = 8'hFF;
      case (acc_index)
         `IDX_FREQ_STRAP_AND_SOURCE_SELECT: wmask = `B0_WRITABLE;
         `IDX_SPREAD_TYPE_AND_PLL3_CONFIG: wmask = `B1_WRITABLE;
         `IDX_UPPER_DIFF_OUTPUT_ENABLES: wmask = `B3_WRITABLE;
         `IDX_CLOCK_REQUEST_E_TO_H_AND_STOP: wmask = `B6_WRITABLE;
         default: wmask = 8'hFF;
      endcase
   end

   always @*
   begin
      idx_next = idx_reg;
      rst_val = 8'h00;
      for (i = 0; i < NBYTES; i = i + 1)
      begin
         byte_next[i] = byte_reg[i];
         case (i)
            0: rst_val = `RST_BYTE0;
            1: rst_val = `RST_BYTE1;
            2: rst_val = `RST_BYTE2;
            3: rst_val = `RST_BYTE3;
            4: rst_val = `RST_BYTE4;
            5: rst_val = `RST_BYTE5;
            default: rst_val = `RST_BYTE6;
         endcase
         // Power-down without retention returns every byte to its default
         if (pd_edge && !byte_reg[0][`B0_KEEP_CFG_BIT])
            byte_next[i] = rst_val;
         else if (wr_strobe && in_range && acc_index == i[6:0])
            byte_next[i] = (byte_reg[i] & ~wmask) | (wr_data & wmask);
      end
      // Pin combination wins over a clearing write in the same cycle
      if (mgmt_combo)
         byte_next[0][`B0_MGMT_BIT] = 1'b1;
      if (xfer_start)
         idx_next = 7'h00;
      else if (single_mode)
         idx_next = idx_reg;
      // Counter stops at the top so a runaway block cannot wrap back onto byte 0
      else if ((wr_strobe || rd_strobe) && idx_reg != 7'h7F)
         idx_next = idx_reg + 7'h01;
   end

   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         byte_reg[0] <= `RST_BYTE0;
         byte_reg[1] <= `RST_BYTE1;
         byte_reg[2] <= `RST_BYTE2;
         byte_reg[3] <= `RST_BYTE3;
         byte_reg[4] <= `RST_BYTE4;
         byte_reg[5] <= `RST_BYTE5;
         byte_reg[6] <= `RST_BYTE6;
         idx_reg <= 7'h00;
         pd_seen_reg <= 1'b0;
      end
      else
      begin
         for (i = 0; i < NBYTES; i = i + 1)
            byte_reg[i] <= byte_next[i];
         idx_reg <= idx_next;
         pd_seen_reg <= power_down_pin;
      end
   end

   // Serial port answers, kept apart from the register bytes they report on
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         addr_ack <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         cmd_error <= 1'b0;
      end
      else
      begin
         addr_ack <= addr_valid && (addr_byte[7:1] == `SERIAL_ADDR_7BIT);
         rd_valid <= rd_strobe;
         if (rd_strobe)
            rd_data <= in_range ? rd_mux : 8'h00;
         // Block access with a nonzero index is flagged but still runs at the block counter, idx_reg
         cmd_error <= (wr_strobe || rd_strobe) && !single_mode && cmd_index != 7'h00;
      end
   end

   // Output 5 has no enable bit in any byte; reset turns it on, and it is off from the first clock after reset
   always @*
   begin
      diff_oe_next = 12'h000;
      diff_oe_next[11] = byte_reg[3][7];
      diff_oe_next[10] = byte_reg[3][6] & ~req_h_idle;
      diff_oe_next[9] = byte_reg[3][5] & ~req_g_idle;
      diff_oe_next[8] = byte_reg[3][4] & ~req_f_idle;
      diff_oe_next[7] = byte_reg[3][3];
      diff_oe_next[6] = byte_reg[3][2] & ~req_e_idle;
      diff_oe_next[4] = byte_reg[3][0] & ~stop_out4;
      diff_oe_next[3] = byte_reg[4][7];
      diff_oe_next[2] = byte_reg[4][6] & ~stop_out2;
      diff_oe_next[1] = byte_reg[4][5] & ~stop_out1;
      diff_oe_next[0] = byte_reg[4][4] & ~stop_out0;
   end

   // Decoded controls; all registered so outputs come from flip-flops
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         single_ended_oe <= 8'hFF;
         diff_ref_oe <= 12'hFFF;
         cpu_oe <= 2'h3;
         mgmt_mode <= 1'b0;
         main_src_is_pll3 <= 1'b0;
         storage_src_is_pll2 <= 1'b0;
         dot_selected <= 1'b0;
         spread_center <= 2'h0;
         spread_on <= 2'h3;
         pll_three_cfg <= 4'h1;
         panel_clock_run <= 1'b1;
         diff_refs_run <= 1'b1;
      end
      else
      begin
         single_ended_oe <= byte_reg[2];
         diff_ref_oe <= diff_oe_next;
         cpu_oe <= byte_reg[4][3:2];
         mgmt_mode <= byte_reg[0][`B0_MGMT_BIT];
         main_src_is_pll3 <= byte_reg[0][`B0_MAIN_SRC_BIT];
         storage_src_is_pll2 <= byte_reg[0][`B0_STORAGE_SRC_BIT];
         dot_selected <= ~dot_strap_reg;
         spread_center <= byte_reg[1][6:5];
         spread_on <= byte_reg[4][1:0];
         // PLL3 code is ignored while PLL3 drives the main reference
         pll_three_cfg <= byte_reg[0][`B0_MAIN_SRC_BIT] ? 4'h1 : byte_reg[1][4:1];
         panel_clock_run <= ~(byte_reg[6][1] & bus_clock_halt_pin);
         diff_refs_run <= ~(byte_reg[6][0] & bus_clock_halt_pin);
      end
   end
endmodule
`default_nettype wire

/* logic/clock_synth_control_defines.vh */
/*
 Register indices, field positions and power-up values of the clock synthesizer control bytes 0 to 6.
 Assumes it is included by bare name from a design file.
*/
`ifndef CLOCK_SYNTH_CONTROL_DEFINES_VH
`define CLOCK_SYNTH_CONTROL_DEFINES_VH

`define IDX_FREQ_STRAP_AND_SOURCE_SELECT 7'h00
`define IDX_SPREAD_TYPE_AND_PLL3_CONFIG 7'h01
`define IDX_SINGLE_ENDED_OUTPUT_ENABLES 7'h02
`define IDX_UPPER_DIFF_OUTPUT_ENABLES 7'h03
`define IDX_LOWER_DIFF_AND_CPU_ENABLES 7'h04
`define IDX_CLOCK_REQUEST_ROUTING_A_TO_D 7'h05
`define IDX_CLOCK_REQUEST_E_TO_H_AND_STOP 7'h06
`define IDX_LAST 7'h06

`define RST_BYTE0 8'h01
`define RST_BYTE1 8'h03
`define RST_BYTE2 8'hFF
`define RST_BYTE3 8'hFF
`define RST_BYTE4 8'hFF
`define RST_BYTE5 8'h00
`define RST_BYTE6 8'h00

`define B0_WRITABLE 8'h17
`define B1_WRITABLE 8'h7E
`define B3_WRITABLE 8'hFD
`define B6_WRITABLE 8'hF3

`define CMD_SINGLE_BIT 7
`define B0_MGMT_BIT 4
`define B0_MAIN_SRC_BIT 2
`define B0_STORAGE_SRC_BIT 1
`define B0_KEEP_CFG_BIT 0
`define B1_DOT_CHOICE_BIT 7

`define SERIAL_ADDR_WRITE 8'hD2
`define SERIAL_ADDR_7BIT 7'h69

`endif
